// ==== hdl/btcu_branch_unit.v ====
`timescale 1ns/1ps
`include "btcu_regs.vh"

module btcu_branch_unit #(
	parameter XLEN = 32
) (
	input wire ref_clk,
	input wire rst_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire dec_valid,
	output wire dec_ready,
	input wire [31:0] dec_instr,
	input wire [XLEN-1:0] dec_pc,
	input wire cr_busy,
	input wire cr_wr_en,
	input wire [31:0] cr_wr_data,
	output reg pred_valid,
	output reg pred_taken,
	output reg [XLEN-1:0] pred_target,
	output reg res_valid,
	output reg res_taken,
	output reg res_invalid,
	output reg [XLEN-1:0] res_target,
	output reg flush,
	output reg [XLEN-1:0] redirect_pc,
	output reg [XLEN-1:0] return_address_register,
	output reg [XLEN-1:0] loop_count_register
);

	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_EXEC = 2'b10;
	localparam [XLEN-1:0] STEP = `BTCU_INSN_BYTES;

	// ==========================================================
	// Helper functions

	// Word alignment and optional clearing of the upper half
	function [XLEN-1:0] fix_addr;
		input [XLEN-1:0] a;
		input m32;
		integer i;
		begin
			for (i = 0; i < XLEN; i = i + 1) begin
				if (i < 2)
					fix_addr[i] = 1'b0;
				else if (m32 && i >= 32)
					fix_addr[i] = 1'b0;
				else
					fix_addr[i] = a[i];
			end
		end
	endfunction

	// Byte-lane merge of a bus word into the low 32 bits
	function [XLEN-1:0] merge_x;
		input [XLEN-1:0] old;
		input [31:0] dat;
		input [3:0] sel;
		integer i;
		begin
			for (i = 0; i < XLEN; i = i + 1) begin
				if (i < 32 && sel[(i % 32) / 8])
					merge_x[i] = dat[i % 32];
				else
					merge_x[i] = old[i];
			end
		end
	endfunction

	// Form decode: 0 uncond, 1 cond disp, 2 to link, 3 to count
	function [3:0] form_of;
		input [31:0] ins;
		reg [5:0] op;
		reg [9:0] xo;
		begin
			op = ins[`BTCU_OP_HI:`BTCU_OP_LO];
			xo = ins[`BTCU_XO_HI:`BTCU_XO_LO];
			form_of[0] = (op == `BTCU_OP_UNCOND);
			form_of[1] = (op == `BTCU_OP_COND);
			form_of[2] = (op == `BTCU_OP_EXT) &&
				(xo == `BTCU_XO_TO_LINK);
			form_of[3] = (op == `BTCU_OP_EXT) &&
				(xo == `BTCU_XO_TO_COUNT);
		end
	endfunction

	// Target address of any branch form
	function [XLEN-1:0] calc_target;
		input [31:0] ins;
		input [XLEN-1:0] pc;
		input [XLEN-1:0] lnk;
		input [XLEN-1:0] cnt;
		input m32;
		reg [3:0] f;
		reg [XLEN-1:0] li;
		reg [XLEN-1:0] bd;
		reg [XLEN-1:0] disp;
		reg [XLEN-1:0] raw;
		begin
			f = form_of(ins);
			li = {{(XLEN-26){ins[25]}}, ins[25:2], 2'b00};
			bd = {{(XLEN-16){ins[15]}}, ins[15:2], 2'b00};
			disp = f[0] ? li : bd;
			if (ins[`BTCU_F_ABS])
				raw = disp;
			else
				raw = pc + disp;
			if (f[2])
				raw = lnk;
			else if (f[3])
				raw = cnt;
			calc_target = fix_addr(raw, m32);
		end
	endfunction

	// Static prediction from options, hint and sign
	function predict;
		input [31:0] ins;
		reg [4:0] bo;
		reg always_br;
		begin
			bo = ins[25:21];
			always_br = bo[4] & bo[2];
			if (form_of(ins) == 4'b0001)
				predict = 1'b1;
			else
				predict = (always_br | ins[`BTCU_F_SIGN]) ^
					(bo[0] & ~always_br);
		end
	endfunction

	// ==========================================================
	// State

	reg [1:0] state_reg;
	reg [31:0] ins_reg;
	reg [XLEN-1:0] pc_reg;
	reg mode32_reg;
	reg [31:0] condition_register;
	reg st_taken_reg;
	reg st_pred_reg;
	reg st_miss_reg;
	reg st_invalid_reg;
	reg [XLEN-1:0] last_tgt_reg;
	reg [15:0] miss_cnt_reg;

	assign dec_ready = (state_reg == ST_IDLE);

	// ==========================================================
	// Resolution of the held branch

	wire [3:0] form = form_of(ins_reg);
	wire [4:0] bo = ins_reg[25:21];
	wire [4:0] bi = ins_reg[20:16];
	wire is_uncond = form[0];
	wire is_cond = form[1] | form[2] | form[3];
	wire bad_count = form[3] & ~bo[2];
	wire bad_form = ~(is_uncond | is_cond) | bad_count;
	wire cr_bit = condition_register[5'd31 - bi];
	wire need_cr = is_cond & ~bo[4];
	// A condition test waits until the interlock clears
	wire can_resolve = ~(need_cr & cr_busy);
	wire dec_cnt = is_cond & ~bo[2] & ~bad_form;
	wire [XLEN-1:0] count_m1 = loop_count_register -
		{{(XLEN-1){1'b0}}, 1'b1};
	// Bits marked ignored never enter these terms
	wire count_ok = bo[2] |
		((count_m1 != {XLEN{1'b0}}) ^ bo[1]);
	wire cond_ok = bo[4] | (cr_bit == bo[3]);
	wire taken = ~bad_form &
		(is_uncond | (count_ok & cond_ok));
	// Guess and outcome differ on a branch of valid form
	wire mispredict = ~bad_form & (pred_taken != taken);
	wire [XLEN-1:0] tgt = calc_target(ins_reg, pc_reg,
		return_address_register, loop_count_register, mode32_reg);
	wire [XLEN-1:0] next_pc = fix_addr(pc_reg + STEP, mode32_reg);
	// Where fetch resumes once the outcome is known
	wire [XLEN-1:0] resume_pc = taken ? tgt : next_pc;
	wire link_req = ins_reg[`BTCU_F_LINK] & ~bad_form;
	wire resolve = (state_reg == ST_EXEC) & can_resolve;

	// ==========================================================
	// Bus decode

	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// Writes land on the edge at which the master sees ack
	wire wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

	// ==========================================================
	// Register write strobes

	wire wr_ctrl = wb_wr & (wb_adr_i == `BTCU_ADR_CTRL) & wb_sel_i[0];
	wire wr_link = wb_wr & (wb_adr_i == `BTCU_ADR_LINK);
	wire wr_count = wb_wr & (wb_adr_i == `BTCU_ADR_COUNT);
	wire wr_cond = wb_wr & (wb_adr_i == `BTCU_ADR_COND);

	// ==========================================================
	// Sequencer and branch outputs

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			ins_reg <= 32'h0000_0000;
			pc_reg <= {XLEN{1'b0}};
			pred_valid <= 1'b0;
			pred_taken <= 1'b0;
			pred_target <= {XLEN{1'b0}};
			res_valid <= 1'b0;
			res_taken <= 1'b0;
			res_invalid <= 1'b0;
			res_target <= {XLEN{1'b0}};
			flush <= 1'b0;
			redirect_pc <= {XLEN{1'b0}};
			st_taken_reg <= 1'b0;
			st_pred_reg <= 1'b0;
			st_miss_reg <= 1'b0;
			st_invalid_reg <= 1'b0;
			last_tgt_reg <= {XLEN{1'b0}};
			miss_cnt_reg <= 16'h0000;
		end else begin
			pred_valid <= 1'b0;
			res_valid <= 1'b0;
			flush <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				if (dec_valid) begin
					ins_reg <= dec_instr;
					pc_reg <= dec_pc;
					pred_valid <= 1'b1;
					pred_taken <= predict(dec_instr);
					pred_target <= calc_target(dec_instr, dec_pc,
						return_address_register, loop_count_register,
						mode32_reg);
					state_reg <= ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (can_resolve) begin
					res_valid <= 1'b1;
					res_taken <= taken;
					res_invalid <= bad_form;
					res_target <= tgt;
					st_taken_reg <= taken;
					st_pred_reg <= pred_taken;
					st_invalid_reg <= bad_form;
					last_tgt_reg <= tgt;
					st_miss_reg <= 1'b0;
					// Wrong guess: drop the fetched path, refetch
					if (mispredict) begin
						flush <= 1'b1;
						redirect_pc <= resume_pc;
						st_miss_reg <= 1'b1;
						miss_cnt_reg <= miss_cnt_reg + 16'h0001;
					end
					state_reg <= ST_IDLE;
				end
			end
			default: begin
				state_reg <= ST_IDLE;
			end
			endcase
		end
	end

	// ==========================================================
	// Architected registers; branch updates win over the bus

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode32_reg <= `BTCU_CTRL_RST;
			return_address_register <= `BTCU_LINK_RST;
			loop_count_register <= `BTCU_COUNT_RST;
			condition_register <= `BTCU_COND_RST;
		end else begin
			if (wr_ctrl)
				mode32_reg <= wb_dat_i[`BTCU_CTRL_MODE32];
			if (resolve && link_req)
				// Target already formed from the old value
				return_address_register <= next_pc;
			else if (wr_link)
				return_address_register <= merge_x(
					return_address_register, wb_dat_i, wb_sel_i);
			if (resolve && dec_cnt)
				loop_count_register <= count_m1;
			else if (wr_count)
				loop_count_register <= merge_x(
					loop_count_register, wb_dat_i, wb_sel_i);
			if (cr_wr_en)
				condition_register <= cr_wr_data;
			else if (wr_cond)
				condition_register <= merge_x(
					condition_register, wb_dat_i, wb_sel_i);
		end
	end

	// ==========================================================
	// Bus answer: one wait state, unmapped reads give zero

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0000_0000;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
				`BTCU_ADR_CTRL: begin
					wb_dat_o[`BTCU_CTRL_MODE32] <= mode32_reg;
				end
				`BTCU_ADR_LINK: begin
					wb_dat_o <= return_address_register[31:0];
				end
				`BTCU_ADR_COUNT: begin
					wb_dat_o <= loop_count_register[31:0];
				end
				`BTCU_ADR_COND: begin
					wb_dat_o <= condition_register;
				end
				`BTCU_ADR_STATUS: begin
					wb_dat_o[`BTCU_ST_TAKEN] <= st_taken_reg;
					wb_dat_o[`BTCU_ST_PRED] <= st_pred_reg;
					wb_dat_o[`BTCU_ST_MISS] <= st_miss_reg;
					wb_dat_o[`BTCU_ST_INVALID] <= st_invalid_reg;
					wb_dat_o[`BTCU_ST_BUSY] <= state_reg[1];
				end
				`BTCU_ADR_TARGET: begin
					wb_dat_o <= last_tgt_reg[31:0];
				end
				`BTCU_ADR_MISS: begin
					wb_dat_o <= {16'h0000, miss_cnt_reg};
				end
				default: begin
					wb_dat_o <= 32'h0000_0000;
				end
				endcase
			end
		end
	end

endmodule

// ==== hdl/btcu_regs.vh ====
`ifndef BTCU_REGS_VH
`define BTCU_REGS_VH

// ==========================================================
// Register word addresses (byte addresses on the bus)
`define BTCU_ADR_CTRL 8'h00
`define BTCU_ADR_LINK 8'h04
`define BTCU_ADR_COUNT 8'h08
`define BTCU_ADR_COND 8'h0c
`define BTCU_ADR_STATUS 8'h10
`define BTCU_ADR_TARGET 8'h14
`define BTCU_ADR_MISS 8'h18

// ==========================================================
// Reset values
`define BTCU_CTRL_RST 1'b0
`define BTCU_LINK_RST 32'h0000_0000
`define BTCU_COUNT_RST 32'h0000_0000
`define BTCU_COND_RST 32'h0000_0000

// ==========================================================
// Control and status bit positions
`define BTCU_CTRL_MODE32 0
`define BTCU_ST_TAKEN 0
`define BTCU_ST_PRED 1
`define BTCU_ST_MISS 2
`define BTCU_ST_INVALID 3
`define BTCU_ST_BUSY 4

// ==========================================================
// Instruction field positions (bit 0 is the least significant)
`define BTCU_F_LINK 0
`define BTCU_F_ABS 1
`define BTCU_F_SIGN 15
`define BTCU_OP_HI 31
`define BTCU_OP_LO 26
`define BTCU_XO_HI 10
`define BTCU_XO_LO 1

// ==========================================================
// Primary and extended opcodes of the branch forms
`define BTCU_OP_UNCOND 6'h12
`define BTCU_OP_COND 6'h10
`define BTCU_OP_EXT 6'h13
`define BTCU_XO_TO_LINK 10'h010
`define BTCU_XO_TO_COUNT 10'h210

// Bytes per instruction
`define BTCU_INSN_BYTES 4

`endif

// ==== testbench/btcu_branch_unit_monitor.sv ====
`timescale 1ns/1ps
// ==========================================================
// Port checker for the branch unit
module btcu_monitor #(
	parameter XLEN = 32
) (
	input wire ref_clk,
	input wire rst_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	input wire dec_valid,
	input wire dec_ready,
	input wire [31:0] dec_instr,
	input wire [XLEN-1:0] dec_pc,
	input wire cr_busy,
	input wire pred_valid,
	input wire pred_taken,
	input wire res_valid,
	input wire res_taken,
	input wire res_invalid,
	input wire [XLEN-1:0] res_target,
	input wire flush,
	input wire [XLEN-1:0] return_address_register,
	input wire [XLEN-1:0] loop_count_register
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire acc = dec_valid && dec_ready;
	wire [5:0] op = dec_instr[31:26];
	reg [31:0] ins_q;
	reg [XLEN-1:0] pc_q;
	// Accepted branch, held for the two-cycle checks
	always @(posedge ref_clk) begin
		if (acc) begin
			ins_q <= dec_instr;
			pc_q <= dec_pc;
		end
	end
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_accept_pred: assert property (acc |=> pred_valid && !dec_ready)
		else $error("no prediction after accept");
	a_tgt_aligned: assert property (res_valid && !res_invalid |->
		res_target[1:0] == 2'h0) else $error("target not aligned");
	a_rel_target: assert property (acc && op == 6'h12 && !dec_instr[1] |->
		##2 res_target == pc_q + {{6{ins_q[25]}}, ins_q[25:2], 2'h0})
		else $error("relative target wrong");
	a_link_next: assert property (acc && op == 6'h12 && dec_instr[0] |->
		##2 return_address_register == pc_q + 4) else $error("link wrong");
	a_pred_sign: assert property (acc && op == 6'h10 &&
		!(dec_instr[25] && dec_instr[23]) |=> pred_valid &&
		pred_taken == (ins_q[15] ^ ins_q[21])) else $error("prediction wrong");
	a_count_invalid: assert property (acc && op == 6'h13 &&
		dec_instr[10:1] == 10'h210 && !dec_instr[23] |->
		##[2:20] res_valid && res_invalid && !res_taken && !flush)
		else $error("count form not refused");
	a_count_kept: assert property (acc && op == 6'h10 && dec_instr[23] |->
		##2 loop_count_register == $past(loop_count_register, 2))
		else $error("count changed");
	a_flush_miss: assert property (flush |->
		res_valid && res_taken != pred_taken) else $error("flush wrong");
	a_busy_stall: assert property (res_valid && ins_q[31:26] == 6'h10 &&
		!ins_q[25] |-> !$past(cr_busy)) else $error("resolved while busy");
	c_flush: cover property (flush);
	c_invalid: cover property (res_valid && res_invalid);
	c_pred_taken: cover property (pred_valid && pred_taken);
endmodule
bind btcu_branch_unit btcu_monitor #(.XLEN(XLEN)) u_mon (.ref_clk, .rst_n,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o, .dec_valid, .dec_ready, .dec_instr,
	.dec_pc, .pred_valid, .pred_taken, .res_valid, .res_taken, .res_invalid,
	.res_target, .flush, .return_address_register, .loop_count_register,
	.cr_busy);

// ==== testbench/btcu_fetch_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// Fetch side: offers one branch and holds it until taken
module btcu_fetch_model (
	input wire ref_clk,
	input wire rst_n,
	input wire go,
	input wire [31:0] instr_in,
	input wire [31:0] pc_in,
	input wire dec_ready,
	output reg dec_valid,
	output reg [31:0] dec_instr,
	output reg [31:0] dec_pc
);
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_valid <= 1'h0;
			dec_instr <= 32'h0;
			dec_pc <= 32'h0;
		end else if (dec_valid && dec_ready) begin
			dec_valid <= 1'h0;
			// Released lines stop showing the old word
			dec_instr <= ~dec_instr;
			dec_pc <= ~dec_pc;
		end else if (go) begin
			dec_valid <= 1'h1;
			dec_instr <= instr_in;
			dec_pc <= pc_in;
		end
	end
endmodule

// ==== testbench/tb_btcu_branch_unit.sv ====
`timescale 1ns/1ps
`include "btcu_regs.vh"
module tb_btcu_branch_unit;
	logic ref_clk = 1'h0, rst_n = 1'h0, go = 1'h0;
	logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
	logic cr_busy = 1'h0, cr_wr_en = 1'h0, wb_ack_o, dec_valid, dec_ready;
	logic [7:0] wb_adr_i = 8'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, cr_wr_data = 32'h0, ins = 32'h0;
	logic [31:0] pc = 32'h0, wb_dat_o, dec_instr, dec_pc, rdat;
	logic pred_valid, pred_taken, res_valid, res_taken, res_invalid, flush;
	logic [31:0] pred_target, res_target, redirect_pc;
	logic [31:0] return_address_register, loop_count_register;
	int fails = 0, samples_checked = 0;
	btcu_branch_unit dut (.ref_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dec_valid,
		.dec_ready, .dec_instr, .dec_pc, .cr_busy, .cr_wr_en, .cr_wr_data,
		.pred_valid, .pred_taken, .pred_target, .res_valid, .res_taken,
		.res_invalid, .res_target, .flush, .redirect_pc,
		.return_address_register, .loop_count_register);
	btcu_fetch_model fm (.ref_clk, .rst_n, .go, .instr_in(ins), .pc_in(pc),
		.dec_ready, .dec_valid, .dec_instr, .dec_pc);
	initial forever #50 ref_clk = ~ref_clk;
	// ==========================================================
	// Tasks
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task finish_test;
		$display("fails=%0d samples_checked=%0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		do @(posedge ref_clk); while (wb_ack_o !== 1'h1);
		rdat = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
		wb_we_i <= 1'h0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input string n);
		bus(1'h0, a, 32'h0);
		chk(n, e, rdat);
	endtask
	task run(input logic [31:0] p, i, input logic tk, inv, fl,
		input logic [31:0] t, l, c);
		@(posedge ref_clk);
		go <= 1'h1;
		ins <= i;
		pc <= p;
		@(posedge ref_clk);
		go <= 1'h0;
		do @(posedge ref_clk); while (res_valid !== 1'h1);
		chk("taken", {31'h0, tk}, {31'h0, res_taken});
		chk("invalid", {31'h0, inv}, {31'h0, res_invalid});
		chk("flush", {31'h0, fl}, {31'h0, flush});
		if (!inv) begin
			chk("target", t, res_target);
			chk("pred target", t, pred_target);
			chk("pred taken", {31'h0, tk ^ fl}, {31'h0, pred_taken});
		end
		if (fl)
			chk("redirect", tk ? t : p + 32'h4, redirect_pc);
		chk("link", l, return_address_register);
		chk("count", c, loop_count_register);
	endtask
	// ==========================================================
	// Tests
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'h1;
		rd(`BTCU_ADR_LINK, 32'h0, "link reset");
		rd(`BTCU_ADR_COUNT, 32'h0, "count reset");
		rd(8'h1c, 32'h0, "unmapped");
		bus(1'h1, `BTCU_ADR_LINK, 32'h2003);
		bus(1'h1, `BTCU_ADR_COUNT, 32'h2);
		bus(1'h1, `BTCU_ADR_COND, 32'h8000_0000);
		rd(`BTCU_ADR_COND, 32'h8000_0000, "cond");
		run(32'h3000, 32'h4e800021, 1, 0, 0, 32'h2000, 32'h3004, 32'h2);
		run(32'h1000, 32'h4bfffff9, 1, 0, 0, 32'h0ff8, 32'h1004, 32'h2);
		run(32'h1000, 32'h48000102, 1, 0, 0, 32'h0100, 32'h1004, 32'h2);
		run(32'h1000, 32'h4180fffc, 1, 0, 0, 32'h0ffc, 32'h1004, 32'h2);
		run(32'h1000, 32'h41a0fffc, 1, 0, 1, 32'h0ffc, 32'h1004, 32'h2);
		run(32'h1000, 32'h40800008, 0, 0, 0, 32'h1008, 32'h1004, 32'h2);
		run(32'h1000, 32'h42000010, 1, 0, 1, 32'h1010, 32'h1004, 32'h1);
		run(32'h1000, 32'h41400020, 1, 0, 1, 32'h1020, 32'h1004, 32'h0);
		run(32'h1000, 32'h40010004, 1, 0, 1, 32'h1004, 32'h1004, '1);
		run(32'h1000, 32'h4e800420, 1, 0, 0, 32'hfffffffc, 32'h1004, '1);
		run(32'h1000, 32'h4e000420, 0, 1, 0, 32'h0, 32'h1004, '1);
		run(32'h1000, 32'h43e00040, 1, 0, 0, 32'h1040, 32'h1004, '1);
		rd(`BTCU_ADR_MISS, 32'h4, "mispredicts");
		rd(`BTCU_ADR_STATUS, 32'h3, "status");
		rd(`BTCU_ADR_TARGET, 32'h1040, "last target");
		bus(1'h1, `BTCU_ADR_CTRL, 32'h1);
		rd(`BTCU_ADR_CTRL, 32'h1, "mode");
		@(posedge ref_clk);
		rst_n <= 1'h0;
		@(posedge ref_clk);
		rst_n <= 1'h1;
		rd(`BTCU_ADR_MISS, 32'h0, "mispredicts after reset");
		rd(`BTCU_ADR_CTRL, 32'h0, "mode after reset");
		@(posedge ref_clk);
		cr_wr_en <= 1'h1;
		cr_wr_data <= 32'h4000_0000;
		cr_busy <= 1'h1;
		@(posedge ref_clk);
		cr_wr_en <= 1'h0;
		rd(`BTCU_ADR_COND, 32'h4000_0000, "core cond write");
		fork
			run(32'h1000, 32'h41810008, 1, 0, 1, 32'h1008, 0, 0);
			begin
				repeat (4) @(posedge ref_clk);
				chk("stalled", 32'h0, {31'h0, dec_ready});
				cr_busy <= 1'h0;
			end
		join
		finish_test;
	end
	initial begin
		#200000;
		fails++;
		finish_test;
	end
endmodule
